/* logic/mxp_pkg.sv */
// Constants, carrier types and states for the muxed address/data host port
package mxp_pkg;

	// ------------------------------------------------------------
	// How it works
	// - Read config bit 10 clear: wait indicator is active low in bursts.
	// - Read config bit 8 clear: wait asserts with the affected word, not before.
	// - No-wrap bursts insert wait cycles at wordline crossings; host tolerates them.
	// - A cycle latching only low address reuses the upper address latched before.
	// - Synchronous writes clock only their address cycles; reads also clock out their data words.
	// - A write commits on the write enable rising edge, free of the link clock.
	// - Before mux mode the upper address pins are grounded, booting from 128 kB.
	// - Upper address latched with output enable low, then lower; sensing follows.
	// - Synchronous cycles capture addresses on a rising link clock edge.
	// - Entering mux mode clears the held upper address to zero.
	// ------------------------------------------------------------

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [31:0] CFG_OFS  = 32'h0000_0000;
	localparam logic [31:0] ADDR_OFS = 32'h0000_0004;
	localparam logic [31:0] WCNT_OFS = 32'h0000_0008;
	localparam logic [15:0] CFG_RST  = 16'h1800;

	// Read config fields
	localparam int CFG_SYNC_B   = 15;
	localparam int CFG_LAT_LSB  = 11;
	localparam int CFG_LAT_W    = 4;
	localparam int CFG_WPOL_B   = 10;
	localparam int CFG_WTIM_B   = 8;
	localparam int CFG_MODE_B   = 4;
	localparam int CFG_NOWRAP_B = 3;

	// Timing and geometry
	localparam logic [3:0] WL_WAIT_CYC = 4'h2;
	localparam int LOW_W      = 16;
	localparam int BOOT_BYTES = 128 * 1024;
	localparam int WORD_BYTES = 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {MXP_IDLE, MXP_HI, MXP_LAT, MXP_BURST, MXP_WLW} mxp_lst_t;

	typedef struct packed {
		logic        ce_n;
		logic        address_valid_strobe_n;
		logic        oe_n;
		logic        we_n;
		logic [15:0] ad;
	} mxp_lin_t;

	typedef struct packed {
		logic [15:0] ad;
		logic        ad_oe;
		logic        wait_o;
	} mxp_lout_t;

	typedef struct packed {
		logic        stb;
		logic [31:0] addr;
		logic [15:0] data;
	} mxp_wr_t;

endpackage : mxp_pkg

/* logic/mxp_port.sv */
// Device-side muxed port: register slave, link address capture, burst and write path
`timescale 1ns/1ps
module mxp_port #(
	parameter int ADDR_W    = 24,
	parameter int BURST_LEN = 16,
	parameter int WL_WORDS  = 16
) (
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic               link_clk,
	input  wire mxp_pkg::mxp_lin_t  lin,
	input  wire logic [ADDR_W-17:0] a_hi,
	output mxp_pkg::mxp_lout_t      lout,
	output logic [ADDR_W-1:0]       arr_addr,
	input  wire logic [15:0]        arr_rdata,
	output mxp_pkg::mxp_wr_t        wr
);

	// ------------------------------------------------------------
	// Geometry and parameter check
	// ------------------------------------------------------------
	localparam int UW  = ADDR_W - mxp_pkg::LOW_W;
	localparam int BW  = $clog2(BURST_LEN);
	localparam int WLB = $clog2(WL_WORDS);

	generate
		if (ADDR_W < 17 || ADDR_W > 32 || BURST_LEN < 2 || WL_WORDS < 2
			|| (BURST_LEN & (BURST_LEN - 1)) != 0
			|| (WL_WORDS & (WL_WORDS - 1)) != 0
			|| (2 ** mxp_pkg::LOW_W) * mxp_pkg::WORD_BYTES != mxp_pkg::BOOT_BYTES)
		begin : g_bad
			$error("mxp_port: unsupported parameter values");
		end
	endgenerate

	// ------------------------------------------------------------
	// State of each clock domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic              rst1;
		logic              rst2;
		logic [15:0]       rc1;
		logic [15:0]       rc2;
		logic              mode_d;
		mxp_pkg::mxp_lst_t st;
		logic [3:0]        cnt;
		logic [UW-1:0]     upper;
		logic [ADDR_W-1:0] aaddr;
		logic [ADDR_W-1:0] lat_addr;
		logic              tog;
		logic              s1v;
		logic [15:0]       s1d;
		logic              outv;
		logic [15:0]       ad;
		logic              ad_oe;
		logic              wait_o;
	} mxp_ls_t;

	typedef struct packed {
		logic [15:0]       cfg;
		logic              t1;
		logic              t2;
		logic              t3;
		logic [ADDR_W-1:0] lat;
		logic              we1;
		logic              we2;
		logic              we3;
		logic              ce1;
		logic              ce2;
		logic [15:0]       ad1;
		logic [15:0]       ad2;
		logic [15:0]       adp;
		logic              wstb;
		logic [ADDR_W-1:0] waddr;
		logic [15:0]       wdata;
		logic [15:0]       wcnt;
		logic              dp_wr;
		logic [31:0]       dp_ofs;
		logic [31:0]       hrd;
	} mxp_rs_t;

	mxp_ls_t           ls_r;
	mxp_ls_t           ls_nxt;
	mxp_rs_t           rs_r;
	mxp_rs_t           rs_nxt;
	logic              l_mode;
	logic              l_entry;
	logic              l_latch;
	logic              l_rd;
	logic              l_wpol;
	logic              l_wtim;
	logic              l_nowrap;
	logic              l_cross;
	logic              l_wact;
	logic [3:0]        l_lat;
	logic [UW-1:0]     l_up;
	logic [ADDR_W-1:0] l_full;
	logic [ADDR_W-1:0] l_next;
	logic              r_take;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Wait pin level from activity and polarity bit
	function automatic logic mxp_wlvl(input logic act, input logic pol);
		mxp_wlvl = pol ? act : ~act;
	endfunction : mxp_wlvl

	// Register read mux; unmapped offsets read zero
	function automatic logic [31:0] mxp_rd(
		input logic [31:0]       a,
		input logic [15:0]       cfg,
		input logic [ADDR_W-1:0] lat,
		input logic [15:0]       wcnt
	);
		case (a)
			mxp_pkg::CFG_OFS:  mxp_rd = {16'h0000, cfg};
			mxp_pkg::ADDR_OFS: mxp_rd = 32'(lat);
			mxp_pkg::WCNT_OFS: mxp_rd = {16'h0000, wcnt};
			default:           mxp_rd = 32'h0000_0000;
		endcase
	endfunction : mxp_rd

	// ------------------------------------------------------------
	// Link domain decode
	// ------------------------------------------------------------
	// Config fields seen through the level synchroniser
	assign l_mode   = ls_r.rc2[mxp_pkg::CFG_MODE_B];
	assign l_wpol   = ls_r.rc2[mxp_pkg::CFG_WPOL_B];
	assign l_wtim   = ls_r.rc2[mxp_pkg::CFG_WTIM_B];
	assign l_nowrap = ls_r.rc2[mxp_pkg::CFG_NOWRAP_B];
	assign l_lat    = ls_r.rc2[mxp_pkg::CFG_LAT_LSB +: mxp_pkg::CFG_LAT_W];
	assign l_entry  = l_mode && !ls_r.mode_d;

	// Address capture on a link clock edge with strobe low
	assign l_latch = !lin.ce_n && !lin.address_valid_strobe_n;
	assign l_rd    = ls_r.st == mxp_pkg::MXP_LAT || ls_r.st == mxp_pkg::MXP_BURST
		|| ls_r.st == mxp_pkg::MXP_WLW;

	// Upper address: held value in mux mode, grounded pins before it
	assign l_up   = l_mode ? (l_entry ? '0 : ls_r.upper) : a_hi;
	assign l_full = {l_up, lin.ad};

	// Next burst address: linear without wrap, else wraps in burst length
	assign l_next = l_nowrap ? ADDR_W'(ls_r.aaddr + 1'b1)
		: {ls_r.aaddr[ADDR_W-1:BW], BW'(ls_r.aaddr[BW-1:0] + 1'b1)};
	assign l_cross = l_next[WLB-1:0] == '0;

	// Wait activity as seen on the pin
	assign l_wact = ~(lout.wait_o ^ l_wpol);

	// ------------------------------------------------------------
	// Link domain next state
	// ------------------------------------------------------------
	always_comb
	begin
		ls_nxt        = ls_r;
		ls_nxt.rst1   = reset_n;
		ls_nxt.rst2   = ls_r.rst1;
		ls_nxt.rc1    = rs_r.cfg;
		ls_nxt.rc2    = ls_r.rc1;
		ls_nxt.mode_d = l_mode;
		ls_nxt.s1v    = 1'b0;
		// Clear held upper half on entry to mux mode
		if (l_entry)
			ls_nxt.upper = '0;
		if (lin.ce_n)
			ls_nxt.st = mxp_pkg::MXP_IDLE;
		else if (l_latch)
		begin
			if (!lin.oe_n)
			begin
				// First address cycle: upper half
				if (l_mode)
					ls_nxt.upper = lin.ad[UW-1:0];
				ls_nxt.st = mxp_pkg::MXP_HI;
			end
			else
			begin
				// Lower half: full address known, sensing starts
				ls_nxt.aaddr    = l_full;
				ls_nxt.lat_addr = l_full;
				ls_nxt.tog      = ~ls_r.tog;
				ls_nxt.st       = mxp_pkg::MXP_LAT;
				ls_nxt.cnt      = (l_lat == 4'h0) ? 4'h1 : l_lat;
			end
		end
		else
		begin
			case (ls_r.st)
				mxp_pkg::MXP_LAT, mxp_pkg::MXP_WLW:
				begin
					if (ls_r.cnt <= 4'h1)
						ls_nxt.st = mxp_pkg::MXP_BURST;
					else
						ls_nxt.cnt = ls_r.cnt - 4'h1;
				end
				mxp_pkg::MXP_BURST:
				begin
					ls_nxt.s1v   = 1'b1;
					ls_nxt.s1d   = arr_rdata;
					ls_nxt.aaddr = l_next;
					// Wordline crossing stalls a no-wrap burst
					if (l_nowrap && l_cross)
					begin
						ls_nxt.st  = mxp_pkg::MXP_WLW;
						ls_nxt.cnt = mxp_pkg::WL_WAIT_CYC;
					end
				end
				default:
				begin
				end
			endcase
		end
		// Output stage, wait either with data or one cycle ahead
		ls_nxt.outv   = ls_r.s1v;
		ls_nxt.ad     = ls_r.s1d;
		ls_nxt.ad_oe  = l_rd && !lin.oe_n;
		ls_nxt.wait_o = mxp_wlvl(l_rd && (l_wtim ? !ls_nxt.s1v : !ls_r.s1v), l_wpol);
		// Synchronous reset, released through the local synchroniser
		if (!ls_r.rst2)
		begin
			ls_nxt        = '0;
			ls_nxt.rst1   = reset_n;
			ls_nxt.rst2   = ls_r.rst1;
			ls_nxt.wait_o = mxp_wlvl(1'b0, mxp_pkg::CFG_RST[mxp_pkg::CFG_WPOL_B]);
		end
	end

	// Link domain register
	always_ff @(posedge link_clk)
	begin
		ls_r <= ls_nxt;
	end

	// ------------------------------------------------------------
	// Reference domain: register slave and write commit
	// ------------------------------------------------------------
	assign r_take = hsel && htrans[1] && hready;

	always_comb
	begin
		rs_nxt = rs_r;
		// Latched address crosses on a toggle; value is stable by then
		rs_nxt.t1 = ls_r.tog;
		rs_nxt.t2 = rs_r.t1;
		rs_nxt.t3 = rs_r.t2;
		if (rs_r.t2 != rs_r.t3)
			rs_nxt.lat = ls_r.lat_addr;
		// Pin synchronisers for the clockless write path
		rs_nxt.we1 = lin.we_n;
		rs_nxt.we2 = rs_r.we1;
		rs_nxt.we3 = rs_r.we2;
		rs_nxt.ce1 = lin.ce_n;
		rs_nxt.ce2 = rs_r.ce1;
		rs_nxt.ad1 = lin.ad;
		rs_nxt.ad2 = rs_r.ad1;
		rs_nxt.adp = rs_r.ad2;
		// Commit on write enable rising edge, data from before the edge
		rs_nxt.wstb = rs_r.we2 && !rs_r.we3 && !rs_r.ce2;
		if (rs_nxt.wstb)
		begin
			rs_nxt.waddr = rs_r.lat;
			rs_nxt.wdata = rs_r.adp;
			rs_nxt.wcnt  = rs_r.wcnt + 16'h0001;
		end
		// Data phase write to read config
		if (rs_r.dp_wr && rs_r.dp_ofs == mxp_pkg::CFG_OFS)
			rs_nxt.cfg = hwdata[15:0];
		// Address phase capture, read data ready for the data phase
		rs_nxt.dp_wr = 1'b0;
		rs_nxt.hrd   = 32'h0000_0000;
		if (r_take)
		begin
			rs_nxt.dp_wr  = hwrite;
			rs_nxt.dp_ofs = haddr;
			if (!hwrite)
				rs_nxt.hrd = mxp_rd(haddr, rs_nxt.cfg, rs_r.lat, rs_r.wcnt);
		end
		// Enable pin synchronisers reset to the idle high level, no false edge; data pin stages reset to zero
		if (!reset_n)
		begin
			rs_nxt     = '0;
			rs_nxt.cfg = mxp_pkg::CFG_RST;
			rs_nxt.we1 = 1'b1;
			rs_nxt.we2 = 1'b1;
			rs_nxt.we3 = 1'b1;
			rs_nxt.ce1 = 1'b1;
			rs_nxt.ce2 = 1'b1;
		end
	end

	// Reference domain register
	always_ff @(posedge ref_clk)
	begin
		rs_r <= rs_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;  // Zero wait states
	assign hresp     = 1'b0;  // Always OKAY
	assign hrdata    = rs_r.hrd;
	assign arr_addr  = ls_r.aaddr;
	assign lout      = '{ad: ls_r.ad, ad_oe: ls_r.ad_oe, wait_o: ls_r.wait_o};
	assign wr        = '{stb: rs_r.wstb, addr: 32'(rs_r.waddr), data: rs_r.wdata};

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Active-low wait shows low while no word is out
	AST_WAIT_LOW: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		($past(l_rd && !l_wtim && !l_wpol) && !ls_r.outv) |-> !lout.wait_o)
		else $error("wait not driven low for a missing word");

	// Wait with data tracks the word on the pins
	AST_WAIT_WITH: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		$past(l_rd && !l_wtim) |-> (l_wact == !ls_r.outv))
		else $error("wait not aligned with its data word");

	// Wait ahead leads the word by one cycle
	AST_WAIT_AHEAD: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		$past(l_rd && l_wtim) |-> (l_wact == !ls_r.s1v))
		else $error("wait not one cycle ahead of data");

	// Wordline crossing inserts a stall and a missing word
	AST_WL_STALL: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		(ls_r.st == mxp_pkg::MXP_BURST && l_nowrap && l_cross && !lin.ce_n && !l_latch)
		|=> (ls_r.st == mxp_pkg::MXP_WLW && ls_r.cnt == mxp_pkg::WL_WAIT_CYC) ##2 !ls_r.outv)
		else $error("no wait cycles at wordline crossing");

	// Lower-only cycle keeps the held upper half
	AST_UPPER_KEEP: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		(l_latch && lin.oe_n && l_mode && !l_entry)
		|=> ls_r.lat_addr[ADDR_W-1:16] == $past(ls_r.upper))
		else $error("upper address not reused");

	// Upper half taken from the bus with output enable low
	AST_HI_CAP: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		(l_latch && !lin.oe_n && l_mode)
		|=> (ls_r.upper == $past(lin.ad[UW-1:0]) && ls_r.st == mxp_pkg::MXP_HI))
		else $error("upper address not captured");

	// Lower half starts sensing at the captured address
	AST_SENSE: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		(l_latch && lin.oe_n) |=> (ls_r.st == mxp_pkg::MXP_LAT
			&& arr_addr == ls_r.lat_addr && ls_r.lat_addr[15:0] == $past(lin.ad)))
		else $error("sensing not started at lower address");

	// Outside mux mode the upper half follows the grounded pins
	AST_BOOT: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		(l_latch && lin.oe_n && !l_mode)
		|=> ls_r.lat_addr[ADDR_W-1:16] == $past(a_hi))
		else $error("upper address not from pins before mux mode");

	// Mode entry clears the held upper half
	AST_ENTRY: assert property (
		@(posedge link_clk) disable iff (!ls_r.rst2)
		(l_entry && !(l_latch && !lin.oe_n)) |=> ls_r.upper == '0)
		else $error("upper address not cleared on mode entry");

	// Write enable rise commits once with pre-edge data
	AST_WR_COMMIT: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		(rs_r.we2 && !rs_r.we3 && !rs_r.ce2)
		|=> (wr.stb && wr.data == $past(rs_r.adp)) ##1 !wr.stb)
		else $error("write not committed on enable rise");

	// Main scenarios
	CV_TWO_ADDR: cover property (@(posedge link_clk) disable iff (!ls_r.rst2)
		(l_latch && !lin.oe_n) ##1 (l_latch && lin.oe_n));
	CV_BURST: cover property (@(posedge link_clk) disable iff (!ls_r.rst2)
		ls_r.outv ##1 ls_r.outv);
	CV_WL: cover property (@(posedge link_clk) disable iff (!ls_r.rst2)
		ls_r.st == mxp_pkg::MXP_WLW);
	CV_WRITE: cover property (@(posedge ref_clk) disable iff (!reset_n) wr.stb);

endmodule : mxp_port

/* tb/mxp_host.sv */
// Host controller model driving the muxed link of the port
`timescale 1ns/1ps
module mxp_host (
	input  wire logic               link_clk,
	output mxp_pkg::mxp_lin_t       lin,
	input  wire mxp_pkg::mxp_lout_t lout
);
	logic [15:0] q[$];
	int          stalls;

	initial lin = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};

	// ------------------------------------------------------------
	// Address cycles: optional upper half, then lower half
	// ------------------------------------------------------------
	task automatic addr(input bit two, input bit keep, input logic [15:0] hi,
		input logic [15:0] lo);
		if (two)
		begin
			@(posedge link_clk);
			lin <= '{1'b0, 1'b0, 1'b0, 1'b1, hi};
			if (!keep)
			begin
				@(posedge link_clk);
				lin.address_valid_strobe_n <= 1'b1;
				lin.ad    <= ~hi;
			end
		end
		@(posedge link_clk);
		lin <= '{1'b0, 1'b0, 1'b1, 1'b1, lo};
		@(posedge link_clk);
		lin.address_valid_strobe_n <= 1'b1;
	endtask : addr

	// ------------------------------------------------------------
	// Burst read: collect n words, count wait cycles between them
	// ------------------------------------------------------------
	task automatic rd(input bit two, input bit keep, input logic [15:0] hi,
		input logic [15:0] lo, input int n, input bit pol);
		int t = 0;
		q.delete();
		stalls = 0;
		addr(two, keep, hi, lo);
		lin.oe_n <= 1'b0;
		lin.ad   <= ~lo;
		while (q.size() < n && t < 200)
		begin
			@(posedge link_clk);
			lin.ad <= ~lin.ad; // Released bus, no stale value
			t++;
			if (lout.wait_o === pol && q.size() > 0)
				stalls++;
			else if (lout.ad_oe === 1'b1 && lout.wait_o === !pol)
				q.push_back(lout.ad);
		end
		@(posedge link_clk);
		lin <= '{1'b1, 1'b1, 1'b1, 1'b1, ~lin.ad};
	endtask : rd

	// ------------------------------------------------------------
	// Write: clocked address capture, then a free-running strobe
	// ------------------------------------------------------------
	task automatic wr(input bit two, input logic [15:0] hi, input logic [15:0] lo,
		input logic [15:0] d);
		addr(two, 1'b0, hi, lo);
		@(posedge link_clk);
		lin.we_n <= 1'b0;
		lin.ad   <= d;
		repeat (2) @(posedge link_clk);
		lin.we_n <= 1'b1;
		@(posedge link_clk);
		lin.ce_n <= 1'b1;
		lin.ad   <= ~d;
	endtask : wr
endmodule : mxp_host

/* tb/testbench.sv */
// Self-checking bench for the muxed port with host and array models
`timescale 1ns/1ps
module testbench;
	logic               ref_clk   = 1'b0;
	logic               link_clk  = 1'b0;
	logic               reset_n   = 1'b0;
	logic               hsel      = 1'b0;
	logic [31:0]        haddr     = 32'h0000_0000;
	logic [1:0]         htrans    = 2'h0;
	logic               hwrite    = 1'b0;
	logic [31:0]        hwdata    = 32'h0000_0000;
	logic               hreadyout;
	logic               hresp;
	logic [31:0]        hrdata;
	mxp_pkg::mxp_lin_t  lin;
	mxp_pkg::mxp_lout_t lout;
	logic [23:0]        arr_addr;
	logic [15:0]        arr_rdata = 16'h0000;
	mxp_pkg::mxp_wr_t   wr;
	mxp_pkg::mxp_wr_t   wcap;
	int                 wseen     = 0;
	int                 error_cnt = 0;
	int                 n_tests   = 0;
	integer             seed      = 32'hc84d_6721;
	logic [31:0]        rv;
	logic [15:0]        lo;
	logic [7:0]         up;

	always #10 ref_clk = ~ref_clk;
	always #32 link_clk = ~link_clk;

	mxp_port u_dut (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (3'h2),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.link_clk  (link_clk),
		.lin       (lin),
		.a_hi      (8'h00),
		.lout      (lout),
		.arr_addr  (arr_addr),
		.arr_rdata (arr_rdata),
		.wr        (wr)
	);

	mxp_host u_host (
		.link_clk (link_clk),
		.lin      (lin),
		.lout     (lout)
	);

	// ------------------------------------------------------------
	// Array model and write capture
	// ------------------------------------------------------------
	function automatic logic [15:0] word_of(input logic [23:0] a);
		return a[15:0] ^ {a[23:16], 8'h3c};
	endfunction : word_of

	// Array answers half a link cycle after the address moves
	always @(negedge link_clk) arr_rdata <= word_of(arr_addr);

	always @(posedge ref_clk)
		if (wr.stb === 1'b1)
		begin
			wcap  <= wr;
			wseen <= wseen + 1;
		end

	// ------------------------------------------------------------
	// Checking, bus and reporting tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int t = 0;
		@(posedge ref_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++t < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++t < 100);
		q = hrdata;
		hsel <= 1'b0;
	endtask : ahb

	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
		chk(32'(hresp), 32'h0000_0000);
	endtask : rchk

	task automatic burst(input bit two, input bit keep, input logic [15:0] l,
		input int n, input bit nw, input bit pol, input int st);
		logic [23:0] a;
		a = {up, l};
		u_host.rd(two, keep, {8'h00, up}, l, n, pol);
		chk(32'(u_host.q.size()), 32'(n));
		foreach (u_host.q[k])
			chk(32'(u_host.q[k]), 32'(word_of(nw ? a + 24'(k) :
				{a[23:4], a[3:0] + 4'(k)})));
		chk(32'(u_host.stalls), 32'(st));
	endtask : burst

	task automatic end_test(input string s);
		$display("Test %s done at %0t", s, $time);
	endtask : end_test

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge link_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge link_clk);
		rchk(mxp_pkg::CFG_OFS, 32'h0000_1800);
		rchk(32'h0000_000C, 32'h0000_0000);
		ahb(1'b1, mxp_pkg::ADDR_OFS, 32'h0000_FFFF, rv);
		rchk(mxp_pkg::ADDR_OFS, 32'h0000_0000);
		rchk(mxp_pkg::WCNT_OFS, 32'h0000_0000);
		end_test("registers");
		up = 8'h00;
		lo = 16'($random(seed));
		burst(1'b0, 1'b0, lo, 5, 1'b0, 1'b0, 0);
		ahb(1'b1, mxp_pkg::CFG_OFS, 32'h0000_1810, rv);
		rchk(mxp_pkg::CFG_OFS, 32'h0000_1810);
		burst(1'b0, 1'b0, ~lo, 5, 1'b0, 1'b0, 0);
		end_test("boot");
		up = 8'($random(seed));
		burst(1'b1, 1'b1, lo, 4, 1'b0, 1'b0, 0);
		up = 8'($random(seed));
		burst(1'b1, 1'b0, lo, 4, 1'b0, 1'b0, 0);
		lo = 16'($random(seed));
		burst(1'b0, 1'b0, lo, 4, 1'b0, 1'b0, 0);
		u_host.addr(1'b0, 1'b0, 16'h0000, ~lo);
		burst(1'b0, 1'b0, lo, 3, 1'b0, 1'b0, 0);
		end_test("address");
		ahb(1'b1, mxp_pkg::CFG_OFS, 32'h0000_1818, rv);
		burst(1'b0, 1'b0, {lo[15:4], 4'hD}, 6, 1'b1, 1'b0, 2);
		ahb(1'b1, mxp_pkg::CFG_OFS, 32'h0000_1C18, rv);
		burst(1'b0, 1'b0, {lo[15:4], 4'hE}, 6, 1'b1, 1'b1, 2);
		end_test("wait");
		for (int k = 0; k < 3; k++)
		begin
			int w0;
			int t;
			w0 = wseen;
			t = 0;
			rv = $random(seed);
			lo = 16'($random(seed));
			if (k[0])
				up = rv[23:16];
			u_host.wr(k[0], {8'h00, rv[23:16]}, lo, rv[15:0]);
			while (wseen == w0 && t < 10)
			begin
				@(posedge ref_clk);
				t++;
			end
			@(posedge ref_clk);
			chk(32'(wseen), 32'(w0 + 1));
			chk(wcap.addr, {8'h00, up, lo});
			chk(32'(wcap.data), 32'(rv[15:0]));
		end
		rchk(mxp_pkg::WCNT_OFS, 32'h0000_0003);
		rchk(mxp_pkg::ADDR_OFS, {8'h00, up, lo});
		end_test("write");
		report_and_stop;
	end

	// Watchdog against a hung handshake
	initial
	begin
		#400000;
		error_cnt++;
		report_and_stop;
	end
endmodule : testbench
